// File: logic/led_onoff_regs.svh
`ifndef LED_ONOFF_REGS_SVH
`define LED_ONOFF_REGS_SVH

// ==================================================
// Register byte offsets
`define OFF_CTRL          8'h00
`define OFF_STATUS        8'h04
`define OFF_MASK          8'h08
`define OFF_LATCH         8'h0c
`define OFF_SHIFT         8'h10
`define OFF_HOLD          8'h14

// ==================================================
// Field positions and reset values
`define CTRL_FORCE_BLANK  0
`define ST_STROBE_DONE    0
`define ST_HOLD_CAPTURED  1
`define ST_FAULT_SEEN     2
`define ST_SPACING_ERR    3
`define ST_BITS           4
`define CTRL_RESET        1'h0
`define MASK_RESET        4'h0

// ==================================================
// Positions in the synchronised pin vector
`define PIN_SHIFT_CLK     0
`define PIN_STROBE        1
`define PIN_BLANK         2
`define PIN_SERIAL_IN     3
`define PIN_OVERTEMP      4
`define PIN_OPEN_LED      5

// ==================================================
// Timing
`define CLK_PERIOD_NS     20
`define STROBE_TO_SHIFT_NS 100

// ==================================================
// Bus answers
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// File: logic/led_onoff_pkg.sv
package led_onoff_pkg;

	typedef enum logic [1:0] {
		RD_IDLE = 2'h1,
		RD_BUSY = 2'h2
	} rd_state_e;

	typedef logic [1:0] axi_resp_t;

endpackage : led_onoff_pkg

// File: logic/reg_access_if.sv
`timescale 1ns/1ps

interface reg_access_if #(
	parameter int ADDR_W = 8
);
	logic              wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0]       wr_data;
	logic [3:0]        wr_strb;
	logic              wr_err;
	logic [ADDR_W-1:0] rd_addr;
	logic              rd_en;
	logic [31:0]       rd_data;
	logic              rd_err;

	modport port (
		output wr_en, wr_addr, wr_data, wr_strb, rd_addr, rd_en,
		input  wr_err, rd_data, rd_err
	);
	modport regs (
		input  wr_en, wr_addr, wr_data, wr_strb, rd_addr, rd_en,
		output wr_err, rd_data, rd_err
	);
endinterface : reg_access_if

// File: logic/pin_sync.sv
`timescale 1ns/1ps

module pin_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] prev;

	// ==================================================
	// Two-stage synchroniser, edge found after the second stage
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					meta[i]  <= 1'h0;
					level[i] <= 1'h0;
					prev[i]  <= 1'h0;
				end else begin
					meta[i]  <= pin[i];
					level[i] <= meta[i];
					prev[i]  <= level[i];
				end
			end
			assign rise[i] = level[i] & ~prev[i];
		end
	endgenerate
endmodule : pin_sync

// File: logic/axil_port.sv
`timescale 1ns/1ps
`include "led_onoff_regs.svh"

module axil_port #(
	parameter int ADDR_W = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	reg_access_if.port             acc
);
	logic                     aw_held;
	logic                     w_held;
	logic [ADDR_W-1:0]        aw_addr;
	led_onoff_pkg::rd_state_e rd_state;

	// ==================================================
	// Write: address and data are taken in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign acc.wr_en     = aw_held && w_held && !s_axi_bvalid;
	assign acc.wr_addr   = aw_addr;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held     <= 1'h0;
			w_held      <= 1'h0;
			aw_addr     <= '0;
			acc.wr_data <= 32'h0000_0000;
			acc.wr_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'h1;
				aw_addr <= s_axi_awaddr;
			end else if (acc.wr_en) begin
				aw_held <= 1'h0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held      <= 1'h1;
				acc.wr_data <= s_axi_wdata;
				acc.wr_strb <= s_axi_wstrb;
			end else if (acc.wr_en) begin
				w_held <= 1'h0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'h0;
			s_axi_bresp  <= `RESP_OKAY;
		end else if (acc.wr_en) begin
			s_axi_bvalid <= 1'h1;
			s_axi_bresp  <= acc.wr_err ? `RESP_SLVERR : `RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'h0;
		end
	end

	// ==================================================
	// Read: data sampled in the address cycle, answered next
	assign s_axi_arready = (rd_state == led_onoff_pkg::RD_IDLE);
	assign s_axi_rvalid  = (rd_state == led_onoff_pkg::RD_BUSY);
	assign acc.rd_addr   = s_axi_araddr;
	assign acc.rd_en     = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state    <= led_onoff_pkg::RD_IDLE;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			case (rd_state)
				led_onoff_pkg::RD_IDLE: begin
					if (acc.rd_en) begin
						rd_state    <= led_onoff_pkg::RD_BUSY;
						s_axi_rdata <= acc.rd_err ? 32'h0000_0000 : acc.rd_data;
						s_axi_rresp <= acc.rd_err ? `RESP_SLVERR : `RESP_OKAY;
					end
				end
				led_onoff_pkg::RD_BUSY: begin
					if (s_axi_rready) begin
						rd_state <= led_onoff_pkg::RD_IDLE;
					end
				end
				default: rd_state <= led_onoff_pkg::RD_IDLE;
			endcase
		end
	end
endmodule : axil_port

// File: logic/led_onoff_shift_latch.sv
// Summary of operation
// - Serial input enters LSB on shift edge
// - Shift edge moves all bits toward MSB
// - Strobe edge copies shift register to latch
// - Strobe edge loads status into shift register
// - Blanking high holds all sinks off
// - Blanking low and force_blank clear: sinks follow latch bits
// - Blanking rise captures status into hold
// - Serial output is shift register MSB
`timescale 1ns/1ps
`include "led_onoff_regs.svh"

module led_onoff_shift_latch #(
	parameter int CHANNELS = 16,
	parameter int ADDR_W   = 8
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic                shift_clk,
	input  wire logic                serial_in,
	input  wire logic                transfer_strobe,
	input  wire logic                blank,
	input  wire logic [CHANNELS-1:0] open_led_flag,
	input  wire logic                overtemp_warning_flag,
	output logic                     serial_out,
	output logic [CHANNELS-1:0]      sink_output_n,
	output logic                     irq
);
	localparam int PIN_W       = `PIN_OPEN_LED + CHANNELS;
	localparam int GAP_CYCLES  = (`STROBE_TO_SHIFT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int GAP_W       = $clog2(GAP_CYCLES + 1);
	localparam logic [GAP_W-1:0] GAP_MIN = GAP_CYCLES[GAP_W-1:0];
	localparam logic [GAP_W-1:0] GAP_ONE = GAP_W'(1);

	// ==================================================
	// Pin synchronisation
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_lvl;
	logic [PIN_W-1:0] pin_rise;

	assign pin_raw = {open_led_flag, overtemp_warning_flag, serial_in, blank, transfer_strobe, shift_clk};

	pin_sync #(
		.WIDTH (PIN_W)
	) u_pin_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin     (pin_raw),
		.level   (pin_lvl),
		.rise    (pin_rise)
	);

	logic                shift_rise;
	logic                strobe_rise;
	logic                blank_lvl;
	logic                blank_rise;
	logic                sin_lvl;
	logic [CHANNELS-1:0] status_raw;

	assign shift_rise  = pin_rise[`PIN_SHIFT_CLK];
	assign strobe_rise = pin_rise[`PIN_STROBE];
	assign blank_lvl   = pin_lvl[`PIN_BLANK];
	assign blank_rise  = pin_rise[`PIN_BLANK];
	assign sin_lvl     = pin_lvl[`PIN_SERIAL_IN];
	// Top bit carries the over-temperature warning; the last channel's open flag has no room
	assign status_raw  = {pin_lvl[`PIN_OVERTEMP], pin_lvl[`PIN_OPEN_LED +: CHANNELS-1]};

	// ==================================================
	// Register access
	reg_access_if #(.ADDR_W(ADDR_W)) acc ();

	axil_port #(
		.ADDR_W (ADDR_W)
	) u_axil_port (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.acc           (acc.port)
	);

	logic                  force_blank;
	logic [`ST_BITS-1:0]   status;
	logic [`ST_BITS-1:0]   mask;
	logic [`ST_BITS-1:0]   status_set;
	logic [CHANNELS-1:0]   shift_reg;
	logic [CHANNELS-1:0]   latch;
	logic [CHANNELS-1:0]   hold;
	logic [CHANNELS-1:0]   hold_view;
	logic [GAP_W-1:0]      gap_cnt;
	logic                  blank_eff;
	logic                  wr_ctrl;
	logic                  wr_status;
	logic                  wr_mask;

	assign wr_ctrl   = acc.wr_en && acc.wr_strb[0] && (acc.wr_addr == `OFF_CTRL);
	assign wr_status = acc.wr_en && acc.wr_strb[0] && (acc.wr_addr == `OFF_STATUS);
	assign wr_mask   = acc.wr_en && acc.wr_strb[0] && (acc.wr_addr == `OFF_MASK);

	always_comb begin
		case (acc.wr_addr)
			`OFF_CTRL, `OFF_STATUS, `OFF_MASK,
			`OFF_LATCH, `OFF_SHIFT, `OFF_HOLD: acc.wr_err = 1'h0;
			default:                           acc.wr_err = 1'h1;
		endcase
	end

	always_comb begin
		acc.rd_data = 32'h0000_0000;
		acc.rd_err  = 1'h0;
		case (acc.rd_addr)
			`OFF_CTRL:   acc.rd_data[`CTRL_FORCE_BLANK] = force_blank;
			`OFF_STATUS: acc.rd_data[`ST_BITS-1:0] = status;
			`OFF_MASK:   acc.rd_data[`ST_BITS-1:0] = mask;
			`OFF_LATCH:  acc.rd_data[CHANNELS-1:0] = latch;
			`OFF_SHIFT:  acc.rd_data[CHANNELS-1:0] = shift_reg;
			`OFF_HOLD:   acc.rd_data[CHANNELS-1:0] = hold_view;
			default:     acc.rd_err = 1'h1;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			force_blank <= `CTRL_RESET;
		end else if (wr_ctrl) begin
			force_blank <= acc.wr_data[`CTRL_FORCE_BLANK];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask <= `MASK_RESET;
		end else if (wr_mask) begin
			mask <= acc.wr_data[`ST_BITS-1:0];
		end
	end

	// ==================================================
	// Events and interrupt
	always_comb begin
		status_set                    = '0;
		status_set[`ST_STROBE_DONE]   = strobe_rise;
		status_set[`ST_HOLD_CAPTURED] = blank_rise;
		status_set[`ST_FAULT_SEEN]    = blank_rise && (status_raw != '0);
		status_set[`ST_SPACING_ERR]   = shift_rise && (gap_cnt < GAP_MIN);
	end

	// A fresh event beats a write-one-to-clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status <= '0;
		end else begin
			status <= (status & ~(wr_status ? acc.wr_data[`ST_BITS-1:0] : '0)) | status_set;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'h0;
		end else begin
			irq <= |(status & mask);
		end
	end

	// Cycles since the last strobe edge, saturating; a shift exactly GAP_MIN cycles later is legal
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gap_cnt <= GAP_MIN;
		end else if (strobe_rise) begin
			gap_cnt <= GAP_ONE;
		end else if (gap_cnt < GAP_MIN) begin
			gap_cnt <= gap_cnt + GAP_ONE;
		end
	end

	// ==================================================
	// Shift register and output latch
	// status load wins over a colliding shift edge, which would break spacing anyway
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shift_reg <= '0;
		end else if (strobe_rise) begin
			shift_reg <= hold_view;
		end else if (shift_rise) begin
			shift_reg <= {shift_reg[CHANNELS-2:0], sin_lvl};
		end
	end

	assign serial_out = shift_reg[CHANNELS-1];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			latch <= '0;
		end else if (strobe_rise) begin
			latch <= shift_reg;
		end
	end

	// ==================================================
	// Status hold
	// capture on blanking rise
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold <= '0;
		end else if (blank_rise) begin
			hold <= status_raw;
		end
	end

	// hold shown only while blanking is low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_view <= '0;
		end else if (!blank_lvl) begin
			hold_view <= hold;
		end
	end

	// ==================================================
	// Sink outputs
	assign blank_eff = blank_lvl || force_blank;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sink_output_n <= '0;
		end else begin
			sink_output_n <= blank_eff ? '0 : latch;
		end
	end

	// ==================================================
	// Assertions
	// serial input check
	shift_lsb_a: assert property (@(posedge aclk) disable iff (!aresetn)
		shift_rise && !strobe_rise |=> shift_reg[0] == $past(sin_lvl))
		else $error("shift lsb did not take serial input");

	shift_move_a: assert property (@(posedge aclk) disable iff (!aresetn)
		shift_rise && !strobe_rise |=> shift_reg[CHANNELS-1:1] == $past(shift_reg[CHANNELS-2:0]))
		else $error("shift register did not move up");

	gap_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		strobe_rise ##[1:4] shift_rise |=> status[`ST_SPACING_ERR])
		else $error("early shift edge not flagged");

	latch_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
		strobe_rise |=> latch == $past(shift_reg))
		else $error("latch did not copy shift register");

	status_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
		strobe_rise |=> shift_reg == $past(hold_view))
		else $error("status not loaded into shift register");

	blank_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		blank_eff |=> sink_output_n == '0)
		else $error("sink on during blanking");

	sink_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!blank_eff |=> sink_output_n == $past(latch))
		else $error("sink does not follow latch");

	hold_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
		blank_rise |=> hold == $past(status_raw) ##1 blank_lvl || hold_view == $past(hold))
		else $error("status hold capture wrong");

	serial_tail_a: assert property (@(posedge aclk) disable iff (!aresetn)
		shift_rise && !strobe_rise |=> serial_out == $past(shift_reg[CHANNELS-2]))
		else $error("serial output not previous second bit");

	latch_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!strobe_rise |=> $stable(latch))
		else $error("latch changed without strobe");

	sticky_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(status & mask) != '0 |=> irq)
		else $error("interrupt missing for unmasked status");

	strobe_then_shift_c: cover property (@(posedge aclk) disable iff (!aresetn)
		strobe_rise ##[1:40] shift_rise);

	blank_capture_c: cover property (@(posedge aclk) disable iff (!aresetn)
		blank_rise && (status_raw != '0));

	spacing_err_c: cover property (@(posedge aclk) disable iff (!aresetn)
		status_set[`ST_SPACING_ERR]);

	sink_on_c: cover property (@(posedge aclk) disable iff (!aresetn)
		sink_output_n != '0);

endmodule : led_onoff_shift_latch

// File: testbench/display_ctrl.sv
`timescale 1ns/1ps

// ==================================================
// Display controller model: drives the link pins on aclk edges
module display_ctrl (
	input  wire logic        aclk,
	output logic             shift_clk,
	output logic             serial_in,
	output logic             transfer_strobe,
	output logic             blank,
	output logic [15:0]      open_led_flag,
	output logic             overtemp_warning_flag
);
	initial begin
		shift_clk = 1'b0;
		serial_in = 1'b0;
		transfer_strobe = 1'b0;
		blank = 1'b0;
		open_led_flag = 16'h0000;
		overtemp_warning_flag = 1'b0;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc

	// first in ends at bit 15; gap 0 after strobe(0) is only used to break spacing
	task automatic send_word(input logic [15:0] w, input int gap);
		for (int i = 15; i >= 0; i--) begin
			serial_in <= w[i];
			cyc(i == 15 ? gap : 4);
			shift_clk <= 1'b1;
			cyc(4);
			shift_clk <= 1'b0;
		end
		// Line is idle now: never leave the last bit looking valid
		serial_in <= ~w[0];
		cyc(4);
	endtask : send_word

	task automatic strobe(input int post);
		transfer_strobe <= 1'b1;
		cyc(4);
		transfer_strobe <= 1'b0;
		cyc(post);
	endtask : strobe

	task automatic set_blank(input logic v);
		blank <= v;
		cyc(6);
	endtask : set_blank
endmodule : display_ctrl

// File: testbench/testbench.sv
`timescale 1ns/1ps
`include "led_onoff_regs.svh"

module testbench;
	logic        aclk;
	logic        aresetn;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic        shift_clk;
	logic        serial_in;
	logic        transfer_strobe;
	logic        blank;
	logic [15:0] open_led_flag;
	logic        overtemp_warning_flag;
	logic        serial_out;
	logic [15:0] sink_output_n;
	logic        irq;
	int          n_fail = 0;
	int          samples_checked = 0;
	logic [31:0] rd;
	logic [1:0]  rs;
	logic [15:0] stat;

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	led_onoff_shift_latch dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.shift_clk(shift_clk), .serial_in(serial_in), .transfer_strobe(transfer_strobe), .blank(blank),
		.open_led_flag(open_led_flag), .overtemp_warning_flag(overtemp_warning_flag),
		.serial_out(serial_out), .sink_output_n(sink_output_n), .irq(irq));

	display_ctrl ctrl (.aclk(aclk), .shift_clk(shift_clk), .serial_in(serial_in),
		.transfer_strobe(transfer_strobe), .blank(blank), .open_led_flag(open_led_flag),
		.overtemp_warning_flag(overtemp_warning_flag));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict

	// ==================================================
	// Bus master: each wait is bounded, a hang counts as a mismatch
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw;
		logic w;
		int   t;
		aw = 1'b1;
		w = 1'b1;
		t = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			t++;
			if (aw && awready) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end while ((aw || w || bvalid !== 1'b1) && t < 100);
		r = bresp;
		bready <= 1'b0;
		// Let an edge pass so a following call never drives bready twice in one step
		@(posedge aclk);
		if (t >= 100)
			n_fail++;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar;
		int   t;
		ar = 1'b1;
		t = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			t++;
			if (ar && arready) begin
				ar = 1'b0;
				arvalid <= 1'b0;
			end
		end while ((ar || rvalid !== 1'b1) && t < 100);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
		if (t >= 100)
			n_fail++;
	endtask : axi_rd

	// ==================================================
	// Scenarios
	task automatic t_bus;
		axi_rd(`OFF_MASK, rd, rs);
		check("mask reset", rd, 32'h0);
		wstrb <= 4'h0;
		axi_wr(`OFF_MASK, 32'h0000_000f, rs);
		check("no strobe wr resp", rs, `RESP_OKAY);
		wstrb <= 4'hf;
		axi_rd(`OFF_MASK, rd, rs);
		check("no strobe ignored", rd, 32'h0);
		axi_wr(8'h18, 32'hffff_ffff, rs);
		check("unmapped wr resp", rs, `RESP_SLVERR);
		axi_rd(8'h18, rd, rs);
		check("unmapped rd", {rd[29:0], rs}, {30'h0, `RESP_SLVERR});
		axi_wr(`OFF_LATCH, 32'h0000_ffff, rs);
		axi_rd(`OFF_LATCH, rd, rs);
		check("latch read only", rd, 32'h0);
		check("sinks after reset", sink_output_n, 16'h0);
		$display("test bus done");
	endtask : t_bus

	task automatic t_hold;
		ctrl.open_led_flag <= 16'h8421;
		ctrl.overtemp_warning_flag <= 1'b1;
		stat = 16'h8421;
		ctrl.set_blank(1'b1);
		ctrl.set_blank(1'b0);
		ctrl.open_led_flag <= 16'h0f0f;
		ctrl.overtemp_warning_flag <= 1'b0;
		ctrl.cyc(6);
		axi_rd(`OFF_HOLD, rd, rs);
		check("hold capture", rd[15:0], stat);
		$display("test hold done");
	endtask : t_hold

	task automatic t_shift_latch;
		ctrl.send_word(16'ha5c3, 8);
		axi_rd(`OFF_SHIFT, rd, rs);
		check("shift word", rd[15:0], 16'ha5c3);
		check("serial out msb", serial_out, 1'b1);
		check("sinks before strobe", sink_output_n, 16'h0);
		ctrl.strobe(4);
		axi_rd(`OFF_LATCH, rd, rs);
		check("latch word", rd[15:0], 16'ha5c3);
		check("sinks follow latch", sink_output_n, 16'ha5c3);
		axi_rd(`OFF_SHIFT, rd, rs);
		check("status loaded", rd[15:0], stat);
		check("serial out status", serial_out, stat[15]);
		$display("test shift latch done");
	endtask : t_shift_latch

	task automatic t_blank;
		ctrl.set_blank(1'b1);
		check("blank off", sink_output_n, 16'h0);
		ctrl.set_blank(1'b0);
		check("unblank", sink_output_n, 16'ha5c3);
		axi_wr(`OFF_CTRL, 32'h0000_0001, rs);
		ctrl.cyc(2);
		check("force blank", sink_output_n, 16'h0);
		axi_rd(`OFF_CTRL, rd, rs);
		check("force blank read", rd, 32'h1);
		axi_wr(`OFF_CTRL, 32'h0, rs);
		ctrl.cyc(2);
		check("force blank off", sink_output_n, 16'ha5c3);
		// Second strobe latches the status loaded by the first one
		ctrl.strobe(4);
		axi_rd(`OFF_LATCH, rd, rs);
		check("second strobe", rd[15:0], stat);
		check("sinks show status", sink_output_n, stat);
		stat = 16'h0f0f;
		axi_rd(`OFF_SHIFT, rd, rs);
		check("new status loaded", rd[15:0], stat);
		$display("test blank done");
	endtask : t_blank

	task automatic t_irq;
		axi_rd(`OFF_STATUS, rd, rs);
		check("strobe and hold seen", rd[1:0], 2'h3);
		check("irq masked", irq, 1'b0);
		axi_wr(`OFF_STATUS, 32'h0000_000f, rs);
		axi_rd(`OFF_STATUS, rd, rs);
		check("status cleared", rd[3:0], 4'h0);
		// Shift edge only 80 ns after the strobe rise
		ctrl.strobe(0);
		ctrl.send_word(16'h00ff, 0);
		axi_rd(`OFF_STATUS, rd, rs);
		check("spacing flagged", rd[3], 1'b1);
		axi_rd(`OFF_SHIFT, rd, rs);
		check("shift still done", rd[15:0], 16'h00ff);
		axi_wr(`OFF_MASK, 32'h0000_0008, rs);
		ctrl.cyc(2);
		check("irq raised", irq, 1'b1);
		axi_wr(`OFF_STATUS, 32'h0000_0008, rs);
		ctrl.cyc(2);
		check("irq cleared", irq, 1'b0);
		$display("test irq done");
	endtask : t_irq

	initial begin
		aresetn = 1'b0;
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'hf;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		t_bus;
		t_hold;
		t_shift_latch;
		t_blank;
		t_irq;
		give_verdict;
	end

	initial begin
		#200us;
		n_fail++;
		give_verdict;
	end
endmodule : testbench
